/* src/rsh_det_if.sv */
// interface: presence detector sample and result
`timescale 1ns/10ps
interface rsh_det_if;
    logic sample_en;
    logic level;
    logic present;
    modport det (input sample_en, input level, output present);
    modport ctl (output sample_en, output level, input present);
endinterface

/* src/rsh_detector.sv */
// module: edge-activity presence detector for one clock input
`timescale 1ns/10ps
module rsh_detector
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // detector link
    rsh_det_if.det    dif
);
    typedef struct packed {
        logic       last;
        logic [5:0] idle;
        logic       present;
    } rsh_det_s;

    rsh_det_s st_reg;
    rsh_det_s st_next;

    // absence needs a full window of samples without an edge
    always_comb
    begin
        st_next = st_reg;
        if (dif.sample_en)
        begin
            st_next.last = dif.level;
            if (dif.level != st_reg.last)
            begin
                st_next.idle    = 6'h00;
                st_next.present = 1'b1;
            end
            else if (st_reg.idle == rsh_pkg::DET_WINDOW)
                st_next.present = 1'b0;
            else
                st_next.idle = st_reg.idle + 6'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign dif.present = st_reg.present;
endmodule // rsh_detector

/* src/rsh_pkg.sv */
// package: register map, field layouts and constants of the reference selector
package rsh_pkg;
    // register offsets
    localparam logic [7:0] CAL_CTRL_OFS    = 8'h0e;
    localparam logic [7:0] BAND_OVR_OFS    = 8'h10;
    localparam logic [7:0] CRYSTAL_INPUT_TUNE_OFS   = 8'h1b;
    localparam logic [7:0] REF_SW_OFS      = 8'h29;
    localparam logic [7:0] REF_CFG_OFS     = 8'h2a;
    localparam logic [7:0] FB_DIV_LO_OFS   = 8'h2b;
    localparam logic [7:0] FB_DIV_MID_OFS  = 8'h2c;
    localparam logic [7:0] FB_DIV_HI_OFS   = 8'h2d;
    localparam logic [7:0] SEL_STAT_OFS    = 8'h2e;
    // field positions
    localparam int CAL_GO_BIT      = 7;
    localparam int CAL_SRC_BIT     = 2;
    localparam int BAND_SRC_BIT    = 0;
    localparam int CRYSTAL_INPUT_SRC_BIT    = 7;
    localparam int MODE_HI         = 7;
    localparam int MODE_LO         = 6;
    localparam int DIFF_BIT        = 0;
    localparam int PRE_A_BIT       = 1;
    localparam int DBL_A_BIT       = 2;
    localparam int PRE_B_BIT       = 3;
    localparam int DBL_B_BIT       = 4;
    // reset values
    localparam logic [7:0] CAL_CTRL_RST   = 8'h00;
    localparam logic [7:0] BAND_OVR_RST   = 8'h00;
    // tuning-source bit set: pins own the load, register field sits at top
    localparam logic [7:0] CRYSTAL_INPUT_TUNE_RST  = 8'hbf;
    localparam logic [7:0] REF_SW_RST     = 8'h00;
    localparam logic [7:0] REF_CFG_RST    = 8'h00;
    // load capacitance in quarter-pF steps
    localparam logic [5:0] CRYSTAL_INPUT_PIN_STEPS = 6'h08;
    localparam logic [6:0] CRYSTAL_INPUT_FIX_STEPS = 7'h20;
    // feedback divider
    localparam int          FB_DIV_W      = 20;
    localparam logic [19:0] FB_DIV_MIN    = 20'h00020;
    localparam logic [19:0] FB_DIV_RST    = 20'h00020;
    // vco calibration
    localparam int          BAND_W        = 7;
    localparam int          CAL_CYC       = 128;
    // presence detector: window of feedback-clock samples
    localparam int          DET_W         = 6;
    localparam logic [5:0]  DET_WINDOW    = 6'h3f;
    // selection modes
    typedef enum logic [1:0] {
        RSH_REVERT   = 2'b00,
        RSH_NONREV   = 2'b01,
        RSH_MAN_PRI  = 2'b10,
        RSH_MAN_SEC  = 2'b11
    } rsh_mode_e;
    // selected source, one-hot
    typedef enum logic [3:0] {
        RSH_SRC_NONE = 4'b0001,
        RSH_SRC_PRI  = 4'b0010,
        RSH_SRC_SEC  = 4'b0100,
        RSH_SRC_CRYSTAL_INPUT = 4'b1000
    } rsh_src_e;
endpackage

/* src/rsh_top.sv */
// module: reference switchover, holdover and pll control registers
`timescale 1ns/10ps
// ======================================================================
// Summary of operation
// - default two single-ended refs; differential mode leaves one ref, no switch
// - crystal load is fixed 8 pF plus programmable 0 to 15.75 pF
// - after reset programmable load is 2 pF, total 10 pF
// - six-bit tuning field, 0.25 pF per step
// - tuning-source bit at 0 hands load to field, 23.75 pF by default
// - each reference path has divide-by-five ahead of optional doubler
// - three presence detectors, each sampled by the pll feedback clock
// - both refs gone selects crystal if present, never in manual codes
// - with nothing present wait, then select per mode and pin
// - reset sets the mode field to 00, revertive
// - revertive: primary whenever present, else secondary, back to primary
// - nonrevertive: start on primary, stay on secondary until it fails
// - codes 10 and 11 pick primary or secondary, only while present
// - force-secondary pin high picks secondary when present
// - 128 vco bands chosen by calibration started at reset
// - cal-source bit then calibrate bit runs a calibration
// - band-source bit makes the seven-bit band field the vco band
// - 20-bit feedback divider, values below 32 not allowed
module rsh_top
(
    // clock and reset
    clk,
    rst_n,
    // register port
    reg_wr,
    reg_rd,
    reg_addr,
    reg_wdata,
    reg_rdata,
    serial_mode,
    // clock inputs and pins
    primary_reference_input,
    secondary_reference_input,
    crystal_input,
    force_secondary_pin,
    fb_sample_en,
    // pll controls
    sel_src,
    diff_mode,
    prescale_a,
    double_a,
    prescale_b,
    double_b,
    crystal_input_load_steps,
    vco_band,
    cal_busy,
    fb_div
);
    // clock and reset
    input  wire logic                     clk;
    input  wire logic                     rst_n;

    // register port
    input  wire logic                     reg_wr;
    input  wire logic                     reg_rd;
    input  wire logic [7:0]               reg_addr;
    input  wire logic [7:0]               reg_wdata;
    output      logic [7:0]               reg_rdata;
    input  wire logic                     serial_mode;

    // clock inputs and pins
    input  wire logic                     primary_reference_input;
    input  wire logic                     secondary_reference_input;
    input  wire logic                     crystal_input;
    input  wire logic                     force_secondary_pin;
    input  wire logic                     fb_sample_en;

    // pll controls
    output      logic [3:0]               sel_src;
    output      logic                     diff_mode;
    output      logic                     prescale_a;
    output      logic                     double_a;
    output      logic                     prescale_b;
    output      logic                     double_b;
    output      logic [6:0]               crystal_input_load_steps;
    output      logic [6:0]               vco_band;
    output      logic                     cal_busy;
    output      logic [19:0]              fb_div;

    // ==================================================================
    // presence detectors
    rsh_det_if pri_if ();
    rsh_det_if sec_if ();
    rsh_det_if xt_if ();

    // every detector is paced by the feedback-clock sample enable
    assign pri_if.sample_en = fb_sample_en;
    assign sec_if.sample_en = fb_sample_en;
    assign xt_if.sample_en  = fb_sample_en;
    assign pri_if.level     = primary_reference_input;
    assign sec_if.level     = secondary_reference_input;
    assign xt_if.level      = crystal_input;

    rsh_detector u_det_pri (.clk(clk), .rst_n(rst_n), .dif(pri_if));
    rsh_detector u_det_sec (.clk(clk), .rst_n(rst_n), .dif(sec_if));
    rsh_detector u_det_xt  (.clk(clk), .rst_n(rst_n), .dif(xt_if));

    // ==================================================================
    // state
    typedef struct packed {
        logic [7:0]         cal_ctrl;
        logic [7:0]         band_ovr;
        logic [7:0]         crystal_input_tune;
        logic [7:0]         ref_sw;
        logic [7:0]         ref_cfg;
        logic [19:0]        fb_div;
        logic [7:0]         rdata;
        rsh_pkg::rsh_src_e  src;
        logic               cal_pend;
        logic [7:0]         cal_cnt;
        logic               busy;
        logic [6:0]         cal_band;
        logic [6:0]         band;
        logic [6:0]         load;
    } rsh_top_s;

    rsh_top_s st_reg;
    rsh_top_s st_next;

    // ==================================================================
    // helper functions
    // clamp illegal divider values to the legal floor
    function automatic logic [19:0] rsh_fb_clamp(input logic [19:0] v);
        rsh_fb_clamp = (v < rsh_pkg::FB_DIV_MIN) ? rsh_pkg::FB_DIV_MIN : v;
    endfunction

    // read mux; unmapped offsets read as zero
    function automatic logic [7:0] rsh_read(input rsh_top_s s,
                                            input logic [7:0] a,
                                            input logic [3:0] det);
        unique case (a)
            rsh_pkg::CAL_CTRL_OFS:   rsh_read = s.cal_ctrl;
            rsh_pkg::BAND_OVR_OFS:   rsh_read = s.band_ovr;
            rsh_pkg::CRYSTAL_INPUT_TUNE_OFS:  rsh_read = s.crystal_input_tune;
            rsh_pkg::REF_SW_OFS:     rsh_read = s.ref_sw;
            rsh_pkg::REF_CFG_OFS:    rsh_read = s.ref_cfg;
            rsh_pkg::FB_DIV_LO_OFS:  rsh_read = s.fb_div[7:0];
            rsh_pkg::FB_DIV_MID_OFS: rsh_read = s.fb_div[15:8];
            rsh_pkg::FB_DIV_HI_OFS:  rsh_read = {4'h0, s.fb_div[19:16]};
            rsh_pkg::SEL_STAT_OFS:   rsh_read = {s.cal_cnt != 8'h00,
                                                 det[2:0], s.src};
            default:                 rsh_read = 8'h00;
        endcase
    endfunction

    // ==================================================================
    // selection inputs
    logic p_ok;
    logic s_ok;
    logic x_ok;
    logic diff;
    rsh_pkg::rsh_mode_e mode;
    rsh_pkg::rsh_src_e  auto_src;

    assign diff = st_reg.ref_cfg[rsh_pkg::DIFF_BIT];
    // mode field decoded once for selection
    assign mode = rsh_pkg::rsh_mode_e'(
                  st_reg.ref_sw[rsh_pkg::MODE_HI:rsh_pkg::MODE_LO]);
    assign p_ok = pri_if.present;
    // in differential mode the second pin is only the complement
    assign s_ok = sec_if.present & ~diff;
    assign x_ok = xt_if.present;

    // ==================================================================
    // source selection
    always_comb
    begin
        auto_src = rsh_pkg::RSH_SRC_NONE;
        unique case (mode)
            rsh_pkg::RSH_REVERT:
            begin
                if (p_ok)
                    auto_src = rsh_pkg::RSH_SRC_PRI;
                else if (s_ok)
                    auto_src = rsh_pkg::RSH_SRC_SEC;
                else if (x_ok)
                    auto_src = rsh_pkg::RSH_SRC_CRYSTAL_INPUT;
            end
            rsh_pkg::RSH_NONREV:
            begin
                if (st_reg.src == rsh_pkg::RSH_SRC_SEC && s_ok)
                    auto_src = rsh_pkg::RSH_SRC_SEC;
                else if (p_ok)
                    auto_src = rsh_pkg::RSH_SRC_PRI;
                else if (s_ok)
                    auto_src = rsh_pkg::RSH_SRC_SEC;
                else if (x_ok)
                    auto_src = rsh_pkg::RSH_SRC_CRYSTAL_INPUT;
            end
            rsh_pkg::RSH_MAN_PRI:
            begin
                if (p_ok)
                    auto_src = rsh_pkg::RSH_SRC_PRI;
            end
            rsh_pkg::RSH_MAN_SEC:
            begin
                if (s_ok)
                    auto_src = rsh_pkg::RSH_SRC_SEC;
            end
        endcase
        // pin forcing does not apply against a manual secondary loss
        if (force_secondary_pin && s_ok)
            auto_src = rsh_pkg::RSH_SRC_SEC;
    end

    // ==================================================================
    // registers, calibration and outputs
    always_comb
    begin
        st_next = st_reg;
        // nothing present: hold off until a source shows up
        st_next.src = auto_src;

        // ==============================================================
        // calibration
        // sweeps the bands; a request during a run queues, and a write
        // landing in the start cycle sets pend again after the clear
        if (st_reg.cal_cnt != 8'h00)
        begin
            st_next.cal_cnt  = st_reg.cal_cnt - 8'h01;
            st_next.cal_band = st_reg.cal_band + 7'h01;
        end
        else if (st_reg.cal_pend)
        begin
            st_next.cal_pend = 1'b0;
            st_next.cal_cnt  = 8'(rsh_pkg::CAL_CYC);
            st_next.cal_band = 7'h00;
        end
        // busy is its own flop so the pin carries no decode
        st_next.busy = st_next.cal_cnt != 8'h00;

        // ==============================================================
        // register writes
        // register port ignored outside serial-mode pin pattern
        if (reg_wr && serial_mode)
        begin
            unique case (reg_addr)
                rsh_pkg::CAL_CTRL_OFS:
                begin
                    // go bit self-clears; one request per write
                    st_next.cal_ctrl = {1'b0, reg_wdata[6:0]};
                    if (reg_wdata[rsh_pkg::CAL_GO_BIT]
                        && st_reg.cal_ctrl[rsh_pkg::CAL_SRC_BIT])
                        st_next.cal_pend = 1'b1;
                end
                rsh_pkg::BAND_OVR_OFS:
                begin
                    st_next.band_ovr = reg_wdata;
                end
                rsh_pkg::CRYSTAL_INPUT_TUNE_OFS:
                begin
                    st_next.crystal_input_tune = reg_wdata;
                end
                rsh_pkg::REF_SW_OFS:
                begin
                    st_next.ref_sw = reg_wdata;
                end
                rsh_pkg::REF_CFG_OFS:
                begin
                    st_next.ref_cfg = reg_wdata;
                end
                rsh_pkg::FB_DIV_LO_OFS:
                begin
                    st_next.fb_div = rsh_fb_clamp(
                        {st_reg.fb_div[19:8], reg_wdata});
                end
                rsh_pkg::FB_DIV_MID_OFS:
                begin
                    st_next.fb_div = rsh_fb_clamp(
                        {st_reg.fb_div[19:16], reg_wdata,
                         st_reg.fb_div[7:0]});
                end
                rsh_pkg::FB_DIV_HI_OFS:
                begin
                    st_next.fb_div = rsh_fb_clamp(
                        {reg_wdata[3:0], st_reg.fb_div[15:0]});
                end
                default:
                begin
                end
            endcase
        end

        // ==============================================================
        // read port
        if (reg_rd && serial_mode)
            st_next.rdata = rsh_read(st_reg, reg_addr,
                                     {1'b0, x_ok, s_ok, p_ok});

        // ==============================================================
        // band and crystal load
        st_next.band = st_reg.cal_ctrl[rsh_pkg::BAND_SRC_BIT]
                       ? st_reg.band_ovr[7:1] : st_reg.cal_band;
        // fixed 8 pF plus quarter-pF steps
        st_next.load = rsh_pkg::CRYSTAL_INPUT_FIX_STEPS + 7'(
                       st_reg.crystal_input_tune[rsh_pkg::CRYSTAL_INPUT_SRC_BIT]
                       ? rsh_pkg::CRYSTAL_INPUT_PIN_STEPS
                       : st_reg.crystal_input_tune[5:0]);
    end

    // ==================================================================
    // state register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_reg           <= '0;
            st_reg.cal_ctrl  <= rsh_pkg::CAL_CTRL_RST;
            st_reg.band_ovr  <= rsh_pkg::BAND_OVR_RST;
            st_reg.crystal_input_tune <= rsh_pkg::CRYSTAL_INPUT_TUNE_RST;
            st_reg.ref_sw    <= rsh_pkg::REF_SW_RST;
            st_reg.ref_cfg   <= rsh_pkg::REF_CFG_RST;
            st_reg.fb_div    <= rsh_pkg::FB_DIV_RST;
            st_reg.src       <= rsh_pkg::RSH_SRC_NONE;
            st_reg.cal_pend  <= 1'b1;
            st_reg.load      <= rsh_pkg::CRYSTAL_INPUT_FIX_STEPS
                                + 7'(rsh_pkg::CRYSTAL_INPUT_PIN_STEPS);
        end
        else
            st_reg <= st_next;
    end

    // ==================================================================
    // outputs
    assign reg_rdata       = st_reg.rdata;
    assign sel_src         = st_reg.src;
    assign diff_mode       = st_reg.ref_cfg[rsh_pkg::DIFF_BIT];
    // prescaler sits ahead of the doubler in each path
    assign prescale_a      = st_reg.ref_cfg[rsh_pkg::PRE_A_BIT];
    assign double_a        = st_reg.ref_cfg[rsh_pkg::DBL_A_BIT];
    assign prescale_b      = st_reg.ref_cfg[rsh_pkg::PRE_B_BIT];
    assign double_b        = st_reg.ref_cfg[rsh_pkg::DBL_B_BIT];
    assign crystal_input_load_steps = st_reg.load;
    assign vco_band        = st_reg.band;
    assign cal_busy        = st_reg.busy;
    assign fb_div          = st_reg.fb_div;
endmodule // rsh_top

/* tb/reference_switchover_holdover_tb.sv */
// testbench: register and source sequences for the reference selector
`timescale 1ns/10ps
module reference_switchover_holdover_tb;
    logic        clk, rst_n, reg_wr, reg_rd, serial_mode, force_pin, fb_en;
    logic        on_pri, on_sec, on_crystal_input, pri_in, sec_in, crystal_input_in, cal_busy;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [3:0]  sel_src;
    wire  [4:0]  cfg;
    logic [6:0]  crystal_input_load_steps, vco_band;
    logic [19:0] fb_div;
    int          fail_count = 0, num_checks = 0, cyc = 0, n;

    rsh_top u_rsh_top (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .serial_mode(serial_mode),
        .primary_reference_input(pri_in), .secondary_reference_input(sec_in),
        .crystal_input(crystal_input_in), .force_secondary_pin(force_pin),
        .fb_sample_en(fb_en), .sel_src(sel_src), .diff_mode(cfg[0]),
        .prescale_a(cfg[1]), .double_a(cfg[2]), .prescale_b(cfg[3]),
        .double_b(cfg[4]), .crystal_input_load_steps(crystal_input_load_steps),
        .vco_band(vco_band), .cal_busy(cal_busy), .fb_div(fb_div));
    rsh_ref_src u_rsh_ref_src (.clk(clk), .on_pri(on_pri), .on_sec(on_sec),
        .on_crystal_input(on_crystal_input), .pri_out(pri_in), .sec_out(sec_in),
        .crystal_input_out(crystal_input_in), .fb_tick(fb_en));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one access; settles two extra cycles so registered outputs are ready
    task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        repeat (2) @(posedge clk);
        if (!w)
            chk(reg_rdata, d);
    endtask

    task automatic wait_src(input logic [3:0] e);
        n = 0;
        while (sel_src !== e && n++ < 400) @(posedge clk);
        chk(sel_src, e);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk)
        if (++cyc == 30000)
        begin
            fail_count++;
            results();
        end

    initial
    begin
        {rst_n, reg_wr, reg_rd, force_pin, on_pri, on_sec, on_crystal_input} = 7'h00;
        {serial_mode, reg_addr, reg_wdata} = 17'h10000;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(cal_busy, 1'b1);
        chk(sel_src, 4'h1);
        acc(0, 8'h29, 8'h00);
        acc(0, 8'h1b, 8'hbf);
        {on_pri, on_sec, on_crystal_input} <= 3'h7;
        wait_src(4'h2);
        on_pri <= 1'b0;
        wait_src(4'h4);
        on_pri <= 1'b1;
        wait_src(4'h2);
        acc(1, 8'h29, 8'h40);
        on_pri <= 1'b0;
        wait_src(4'h4);
        on_pri <= 1'b1;
        repeat (200) @(posedge clk);
        chk(sel_src, 4'h4);
        on_sec <= 1'b0;
        wait_src(4'h2);
        on_pri <= 1'b0;
        wait_src(4'h8);
        acc(1, 8'h29, 8'hc0);
        on_sec <= 1'b1;
        wait_src(4'h4);
        acc(1, 8'h29, 8'h80);
        on_pri <= 1'b1;
        wait_src(4'h2);
        force_pin <= 1'b1;
        wait_src(4'h4);
        acc(1, 8'h1b, 8'h3f);
        chk(crystal_input_load_steps, 7'd95);
        acc(1, 8'h1b, 8'h00);
        chk(crystal_input_load_steps, 7'd32);
        serial_mode <= 1'b0;
        acc(1, 8'h1b, 8'h3f);
        serial_mode <= 1'b1;
        chk(crystal_input_load_steps, 7'd32);
        acc(1, 8'h2a, 8'h1f);
        chk(cfg, 5'h1f);
        wait_src(4'h2);
        acc(1, 8'h2d, 8'h0f);
        acc(1, 8'h2c, 8'hff);
        acc(1, 8'h2b, 8'hff);
        chk(fb_div, 20'hfffff);
        acc(1, 8'h2d, 8'h00);
        acc(1, 8'h2c, 8'h00);
        acc(1, 8'h2b, 8'h1f);
        chk(fb_div, 20'h00020);
        acc(1, 8'h0e, 8'h01);
        acc(1, 8'h10, 8'haa);
        chk(vco_band, 7'h55);
        acc(0, 8'h10, 8'haa);
        acc(1, 8'h0e, 8'h80);
        chk(cal_busy, 1'b0);
        acc(1, 8'h0e, 8'h04);
        acc(1, 8'h0e, 8'h84);
        n = 0;
        while (cal_busy !== 1'b1 && n++ < 8) @(posedge clk);
        chk(cal_busy, 1'b1);
        n = 0;
        while (cal_busy === 1'b1 && n++ < 300) @(posedge clk);
        chk(n, 20'd128);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        acc(0, 8'h29, 8'h00);
        chk(crystal_input_load_steps, 7'h28);
        chk(fb_div, 20'h00020);
        results();
    end
endmodule // reference_switchover_holdover_tb

/* tb/rsh_ref_src.sv */
// partner: reference and crystal sources plus the feedback sampling tick
`timescale 1ns/10ps
module rsh_ref_src
(
    // clock and source enables
    input  wire logic clk,
    input  wire logic on_pri,
    input  wire logic on_sec,
    input  wire logic on_crystal_input,
    // source levels and tick
    output logic      pri_out,
    output logic      sec_out,
    output logic      crystal_input_out,
    output logic      fb_tick
);
    logic tick_reg = 1'b0;
    assign fb_tick = tick_reg;
    // vco free-runs, so the tick ignores reset
    always_ff @(posedge clk)
    begin
        tick_reg <= ~tick_reg;
        if (tick_reg)
        begin
            // slow toggles stay far below doubler and detector limits
            pri_out  <= on_pri & ~pri_out;
            sec_out  <= on_sec & ~sec_out;
            crystal_input_out <= on_crystal_input & ~crystal_input_out;
        end
    end
endmodule // rsh_ref_src

/* tb/rsh_top_props.sv */
// checker: port-level properties of the reference selector
`timescale 1ns/10ps
module rsh_top_props
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        serial_mode,
    // pll controls
    input  wire logic [3:0]  sel_src,
    input  wire logic [6:0]  crystal_input_load_steps,
    input  wire logic [6:0]  vco_band,
    input  wire logic        cal_busy,
    input  wire logic [19:0] fb_div
);
    logic       band_src_reg, manual_reg;
    logic [2:0] manual_hist_reg;
    logic [6:0] band_reg, load_reg;
    logic [9:0] busy_cnt_reg;
    wire        take = reg_wr && serial_mode;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            band_src_reg    <= 1'b0;
            manual_reg      <= 1'b0;
            manual_hist_reg <= 3'h0;
            busy_cnt_reg    <= 10'h000;
        end
        else
        begin
            if (take && reg_addr == 8'h0e)
                band_src_reg <= reg_wdata[0];
            if (take && reg_addr == 8'h29)
                manual_reg <= reg_wdata[7];
            if (take && reg_addr == 8'h10)
                band_reg <= reg_wdata[7:1];
            if (take && reg_addr == 8'h1b)
                load_reg <= reg_wdata[7] ? 7'h28 : 7'h20 + {1'b0, reg_wdata[5:0]};
            manual_hist_reg <= {manual_hist_reg[1:0], manual_reg};
            busy_cnt_reg    <= cal_busy ? busy_cnt_reg + 10'h001 : 10'h000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_band_wr;
        take && reg_addr == 8'h10 && band_src_reg;
    endsequence
    sequence s_load_wr;
        take && reg_addr == 8'h1b;
    endsequence

    reset_values_a:
        assert property ($rose(rst_n) |-> fb_div == 20'h00020
            && crystal_input_load_steps == 7'h28) else $error("bad reset value");
    cal_start_a:
        assert property ($rose(rst_n) |-> ##[1:3] cal_busy)
            else $error("no calibration after reset");
    cal_length_a:
        assert property ($fell(cal_busy) |-> busy_cnt_reg[6:0] == 7'h00
            && busy_cnt_reg != 10'h000) else $error("calibration length");
    fb_floor_a:
        assert property (fb_div >= 20'h00020) else $error("divider below 32");
    one_source_a:
        assert property ($onehot(sel_src)) else $error("source not one-hot");
    no_holdover_a:
        assert property (sel_src == 4'h8 |-> !(manual_reg && &manual_hist_reg))
            else $error("holdover in manual mode");
    band_override_a:
        assert property (s_band_wr |-> ##[1:2] vco_band == band_reg)
            else $error("band override not applied");
    load_tune_a:
        assert property (s_load_wr |-> ##[1:2] crystal_input_load_steps == load_reg)
            else $error("crystal load mismatch");
    port_locked_a:
        assert property (reg_wr && !serial_mode |=> $stable(crystal_input_load_steps)[*2])
            else $error("write taken outside serial mode");
endmodule // rsh_top_props

bind rsh_top rsh_top_props u_rsh_top_props (.clk(clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .serial_mode(serial_mode), .sel_src(sel_src), .vco_band(vco_band),
    .crystal_input_load_steps(crystal_input_load_steps), .cal_busy(cal_busy), .fb_div(fb_div));
